// ---- inc/rfb_pkg.sv ----
/*
  Shared constants for the receive frame boundary port: byte layout of a
  lane word, management port widths, register offsets and field positions.
  Assumes every user of it names items as rfb_pkg::name.
*/
package rfb_pkg;
  // Layout of one lane word on the data bus.
  localparam int BYTES_PER_LANE = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = BYTES_PER_LANE * BYTE_W;
  localparam int POS_W = 16;

  // Management port widths.
  localparam int MGMT_ADDR_W = 12;
  localparam int MGMT_DATA_W = 32;
  localparam int MGMT_STRB_W = MGMT_DATA_W / BYTE_W;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // Register offsets, byte addresses on the management port.
  localparam logic [11:0] REG_FRAME_CFG = 12'h000;
  localparam logic [11:0] REG_LINK_STATUS = 12'h004;

  // Field positions of the frame configuration register.
  localparam int CFG_OCTETS_LSB = 0;
  localparam int CFG_FRAMES_LSB = 8;
  localparam int CFG_SC1_BIT = 16;

  // Reset values: eight octets per frame, 32 frames per multiframe.
  localparam logic [7:0] OCTETS_RST = 8'h08;
  localparam logic [7:0] FRAMES_RST = 8'h20;
  localparam logic SC1_RST = 1'b0;

  // Field positions of the link status register.
  localparam int STAT_SYNC_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
endpackage

// ---- inc/rfb_cfg_if.sv ----
/*
  Carrier between the management slave and the frame boundary core:
  framing configuration one way, link status the other.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/100ps
interface rfb_cfg_if;
  logic [7:0] frame_octets;
  logic [7:0] frames_per_mf;
  logic subclass1_en;
  logic sync_ready;
  logic data_valid;

  // The management end owns configuration and reads status.
  modport mgmt (
    output frame_octets,
    output frames_per_mf,
    output subclass1_en,
    input sync_ready,
    input data_valid
  );

  // The core end reads configuration and reports status.
  modport core (
    input frame_octets,
    input frames_per_mf,
    input subclass1_en,
    output sync_ready,
    output data_valid
  );
endinterface

// ---- rtl/rfb_mgmt.sv ----
/*
  Management slave of the receive frame boundary port, with a 12-bit
  address and 32-bit data, one transaction at a time.
  Assumes the master follows valid/ready handshakes and that the
  management reset is already in the clock's domain.
*/
`timescale 1ns/100ps
module rfb_mgmt (
  // Clock and management reset.
  input wire logic clk_in,
  input wire logic mgmt_resetn_in,
  // Write address and data channels.
  input wire logic [11:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  // Write response channel.
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // Read channels.
  input wire logic [11:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Configuration toward the core.
  rfb_cfg_if.mgmt cfg
);
  typedef enum logic [2:0] {
    RFB_IDLE = 3'h1,
    RFB_WRESP = 3'h2,
    RFB_RDATA = 3'h4
  } rfb_mstate_t;

  typedef struct packed {
    rfb_mstate_t st;
    logic [31:0] cfg;
    logic [31:0] rdata;
  } rfb_mgmt_t;

  rfb_mgmt_t s_q;
  rfb_mgmt_t s_d;
  logic wr_go;
  logic rd_go;

  // Writes need both address and data; they win over a read in one cycle.
  assign wr_go = (s_q.st == RFB_IDLE) && awvalid_in && wvalid_in;
  assign rd_go = (s_q.st == RFB_IDLE) && arvalid_in && !wr_go;
  assign awready_out = wr_go;
  assign wready_out = wr_go;
  assign arready_out = rd_go;
  assign bvalid_out = (s_q.st == RFB_WRESP);
  assign rvalid_out = (s_q.st == RFB_RDATA);
  assign bresp_out = rfb_pkg::RESP_OKAY;
  assign rresp_out = rfb_pkg::RESP_OKAY;
  assign rdata_out = s_q.rdata;

  // Configuration fields fed to the core.
  assign cfg.frame_octets = s_q.cfg[rfb_pkg::CFG_OCTETS_LSB +: 8];
  assign cfg.frames_per_mf = s_q.cfg[rfb_pkg::CFG_FRAMES_LSB +: 8];
  assign cfg.subclass1_en = s_q.cfg[rfb_pkg::CFG_SC1_BIT];

  // Next state: handshake sequencing, strobed writes and read decode.
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      RFB_IDLE: begin
        if (wr_go) begin
          if (awaddr_in == rfb_pkg::REG_FRAME_CFG) begin
            for (int b = 0; b < rfb_pkg::MGMT_STRB_W; b++) begin
              if (wstrb_in[b]) begin
                s_d.cfg[b*rfb_pkg::BYTE_W +: rfb_pkg::BYTE_W] =
                    wdata_in[b*rfb_pkg::BYTE_W +: rfb_pkg::BYTE_W];
              end
            end
          end
          s_d.st = RFB_WRESP;
        end else if (rd_go) begin
          s_d.rdata = 32'h0000_0000; // Unmapped addresses read zero.
          if (araddr_in == rfb_pkg::REG_FRAME_CFG) begin
            s_d.rdata = s_q.cfg;
          end else if (araddr_in == rfb_pkg::REG_LINK_STATUS) begin
            s_d.rdata[rfb_pkg::STAT_SYNC_BIT] = cfg.sync_ready;
            s_d.rdata[rfb_pkg::STAT_VALID_BIT] = cfg.data_valid;
          end
          s_d.st = RFB_RDATA;
        end
      end
      RFB_WRESP: begin
        if (bready_in) begin
          s_d.st = RFB_IDLE;
        end
      end
      RFB_RDATA: begin
        if (rready_in) begin
          s_d.st = RFB_IDLE;
        end
      end
      default: begin
        s_d.st = RFB_IDLE;
      end
    endcase
  end

  // Only the management reset clears this port.
  always_ff @(posedge clk_in) begin
    if (!mgmt_resetn_in) begin
      s_q.st <= RFB_IDLE;
      s_q.cfg <= {15'h0000, rfb_pkg::SC1_RST, rfb_pkg::FRAMES_RST,
                  rfb_pkg::OCTETS_RST};
      s_q.rdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ---- rtl/rfb_top.sv ----
/*
  Receive frame boundary port: passes aligned lane words to user logic,
  marks frame and multiframe boundaries per byte, qualifies byte errors,
  drives the sync request and takes SYSREF in Subclass 1.
  Assumes lane words and alignment status arrive already aligned on the
  core clock; SYSREF arrives from a pin and is synchronised here.
  The management reset is taken to be synchronous to the core clock.
*/
// Notes on behaviour
// - A 4-bit multiframe-begin flag marks the byte holding the first byte of each multiframe.
// - A 4-bit multiframe-last flag marks the byte holding the last byte of each multiframe.
// - One error flag per byte per lane, bit 0 for lane 0 byte 0, top bit for the last lane's top byte.
// - Error flags appear on the core clock one cycle ahead of the bytes they qualify.
// - The active-low sync request stays low until comma alignment, then goes high.
// - Frame begin and end flags are four bits, one per byte, shared by every lane slice.
// - A frame-begin value of 0001 means a frame starts in byte 0 of every lane slice.
// - The data bus carries transport-layer bytes including control words, not samples.
// - Every write on the management port answers OKAY.
// - Every read on the management port answers OKAY.
// - The management port uses 12-bit addresses, 32-bit data and a 4-bit write strobe.
// - In each lane slice the first received byte sits in the lowest byte.
// - The frame-begin flag leads the data word it describes by one cycle.
`timescale 1ns/100ps
module rfb_top #(
  parameter int LANES = 4
) (
  // Core clock and reset.
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Aligned lane words from the lane alignment stage.
  input wire logic [32*LANES-1:0] lane_data_in,
  input wire logic [4*LANES-1:0] lane_byte_err_in,
  input wire logic lane_valid_in,
  input wire logic comma_aligned_in,
  // SYSREF pin.
  input wire logic sysref_in,
  // Received data toward user logic.
  output logic [32*LANES-1:0] rx_tdata_out,
  output logic rx_tvalid_out,
  output logic [3:0] frame_begin_byte_pos_out,
  output logic [3:0] frame_last_byte_pos_out,
  output logic [3:0] multiframe_begin_byte_pos_out,
  output logic [3:0] multiframe_last_byte_pos_out,
  output logic [4*LANES-1:0] rx_frame_error_out,
  output logic rx_sync_n_out,
  // Management port.
  input wire logic s_axi_aresetn_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  localparam int BPL = rfb_pkg::BYTES_PER_LANE;
  localparam int PW = rfb_pkg::POS_W;

  // Core state, all in one register. The pipeline has two word stages:
  // stage one holds the taken word with its boundary and error flags,
  // and stage two drives the data bus. Keeping the flags in stage one is
  // what makes them lead the bytes they describe by one cycle, at the
  // cost of a second full-width data register.
  typedef struct packed {
    logic [PW-1:0] pos;
    logic sysref_s1;
    logic sysref_s2;
    logic sysref_prev;
    logic sync_ready;
    logic valid1;
    logic [32*LANES-1:0] data1;
    logic [BPL-1:0] fbegin;
    logic [BPL-1:0] flast;
    logic [BPL-1:0] mbegin;
    logic [BPL-1:0] mlast;
    logic [4*LANES-1:0] err;
    logic valid2;
    logic [32*LANES-1:0] data2;
  } rfb_core_t;

  rfb_core_t s_q;
  rfb_core_t s_d;
  rfb_cfg_if cfg_bus ();
  logic [PW-1:0] octets;
  logic [PW-1:0] mf_len;
  logic sysref_edge;

  // Offset of a multiframe position within its frame. The modulo costs a
  // real divider; it is accepted because frame lengths need not be powers
  // of two, and the divisor only changes when software writes it.
  function automatic logic [PW-1:0] frame_offset(input logic [PW-1:0] p,
                                                 input logic [PW-1:0] f);
    frame_offset = p % f;
  endfunction

  // Advance a multiframe position by n bytes with wrap. Positions stay
  // below the multiframe length, so one extra bit in the sum holds the
  // carry.
  function automatic logic [PW-1:0] mf_step(input logic [PW-1:0] p,
                                            input logic [PW-1:0] n,
                                            input logic [PW-1:0] m);
    logic [PW:0] sum;
    sum = {1'b0, p} + {1'b0, n};
    mf_step = PW'(sum % {1'b0, m});
  endfunction

  // Zero in the configuration would stall the counters, so clamp to one.
  // Up to 255 frames of 255 octets still fit the 16-bit position.
  // New framing values apply from the next word and the position is not
  // rescaled, so software should force re-alignment after a change.
  assign octets = (cfg_bus.frame_octets == 8'h00) ? PW'(1) :
                  PW'(cfg_bus.frame_octets);
  assign mf_len = octets * ((cfg_bus.frames_per_mf == 8'h00) ? PW'(1) :
                  PW'(cfg_bus.frames_per_mf));
  // SYSREF is a pin: two flops settle it and a third gives the edge, so a
  // rising edge acts three cycles after it reaches the pin.
  assign sysref_edge = s_q.sysref_s2 && !s_q.sysref_prev;

  // Status back to the management port.
  assign cfg_bus.sync_ready = s_q.sync_ready;
  assign cfg_bus.data_valid = s_q.valid2;

  // Outputs straight from flops.
  assign rx_tdata_out = s_q.data2;
  assign rx_tvalid_out = s_q.valid2;
  assign frame_begin_byte_pos_out = s_q.fbegin;
  assign frame_last_byte_pos_out = s_q.flast;
  assign multiframe_begin_byte_pos_out = s_q.mbegin;
  assign multiframe_last_byte_pos_out = s_q.mlast;
  assign rx_frame_error_out = s_q.err;
  assign rx_sync_n_out = s_q.sync_ready;

  // Next state. Flags for a word register with the first data stage, so
  // they lead the second stage, which drives the data bus, by one cycle.
  always_comb begin
    logic [PW-1:0] p;
    p = '0;
    s_d = s_q;
    s_d.sysref_s1 = sysref_in;
    s_d.sysref_s2 = s_q.sysref_s1;
    s_d.sysref_prev = s_q.sysref_s2;
    // The sync request follows comma alignment one cycle late. Words
    // offered before it rises are dropped, though their error flags still
    // pass, so user logic can see a noisy lane during alignment.
    s_d.sync_ready = comma_aligned_in;
    s_d.valid1 = lane_valid_in && s_q.sync_ready;
    s_d.data1 = lane_data_in;
    s_d.err = lane_valid_in ? lane_byte_err_in : '0;
    s_d.valid2 = s_q.valid1;
    s_d.data2 = s_q.data1;
    // One position drives every lane slice, so all lanes share the flags.
    // Byte b of a word lies b bytes past the word's first position.
    for (int b = 0; b < BPL; b++) begin
      p = mf_step(s_q.pos, PW'(b), mf_len);
      s_d.fbegin[b] = s_d.valid1 && (frame_offset(p, octets) == '0);
      s_d.flast[b] = s_d.valid1 &&
                     (frame_offset(p, octets) == octets - PW'(1));
      s_d.mbegin[b] = s_d.valid1 && (p == '0);
      s_d.mlast[b] = s_d.valid1 && (p == mf_len - PW'(1));
    end
    // The position advances by one lane word of bytes per taken word and
    // restarts while the sync request is low, so framing begins afresh
    // after every loss of alignment.
    if (s_d.valid1) begin
      s_d.pos = mf_step(s_q.pos, PW'(BPL), mf_len);
    end else if (!s_q.sync_ready) begin
      s_d.pos = '0;
    end
    // SYSREF realigns the multiframe count; it wins over stepping.
    if (cfg_bus.subclass1_en && sysref_edge) begin
      s_d.pos = '0;
    end
  end

  // Core state register with synchronous reset. A core reset clears every
  // stage, so the sync request is low and all flags are clear at the
  // first edge after release.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Management slave; user logic owns any frame replay.
  // It shares the core clock but has its own reset, so software settings
  // survive a core reset.
  rfb_mgmt u_mgmt (
    .clk_in(ref_clk_in),
    .mgmt_resetn_in(s_axi_aresetn_in),
    .awaddr_in(s_axi_awaddr_in),
    .awvalid_in(s_axi_awvalid_in),
    .awready_out(s_axi_awready_out),
    .wdata_in(s_axi_wdata_in),
    .wstrb_in(s_axi_wstrb_in),
    .wvalid_in(s_axi_wvalid_in),
    .wready_out(s_axi_wready_out),
    .bresp_out(s_axi_bresp_out),
    .bvalid_out(s_axi_bvalid_out),
    .bready_in(s_axi_bready_in),
    .araddr_in(s_axi_araddr_in),
    .arvalid_in(s_axi_arvalid_in),
    .arready_out(s_axi_arready_out),
    .rdata_out(s_axi_rdata_out),
    .rresp_out(s_axi_rresp_out),
    .rvalid_out(s_axi_rvalid_out),
    .rready_in(s_axi_rready_in),
    .cfg(cfg_bus.mgmt)
  );
endmodule

// ---- dv/rfb_props.sv ----
/*
  Checker for the receive frame boundary port, bound into rfb_top.
  Assumes one core clock that also runs the management port.
*/
`timescale 1ns/100ps
module rfb_props #(
  parameter int LANES = 4
) (
  // Clock, reset and inputs.
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [32*LANES-1:0] lane_data_in,
  input wire logic [4*LANES-1:0] lane_byte_err_in,
  input wire logic lane_valid_in,
  input wire logic comma_aligned_in,
  // Outputs under watch.
  input wire logic [32*LANES-1:0] rx_tdata_out,
  input wire logic rx_tvalid_out,
  input wire logic [3:0] frame_begin_byte_pos_out,
  input wire logic [3:0] frame_last_byte_pos_out,
  input wire logic [3:0] multiframe_begin_byte_pos_out,
  input wire logic [3:0] multiframe_last_byte_pos_out,
  input wire logic [4*LANES-1:0] rx_frame_error_out,
  input wire logic rx_sync_n_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out
);
  // A single domain, so clocking and disable are set once here.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  sync_follow_a: assert property ($past(resetn_in) |->
    rx_sync_n_out == $past(comma_aligned_in)) else $error("sync late");
  tvalid_lat_a: assert property (
    $past(resetn_in) && $past(resetn_in, 2) |->
    rx_tvalid_out == $past(lane_valid_in && rx_sync_n_out, 2))
    else $error("tvalid latency wrong");
  data_pass_a: assert property (rx_tvalid_out |->
    rx_tdata_out == $past(lane_data_in, 2)) else $error("data mismatch");
  err_lead_a: assert property ($past(resetn_in) |->
    rx_frame_error_out == ($past(lane_valid_in) ?
    $past(lane_byte_err_in) : '0)) else $error("error flags wrong");
  begin_lead_a: assert property (|frame_begin_byte_pos_out |=>
    rx_tvalid_out) else $error("frame begin without data");
  last_lead_a: assert property (|frame_last_byte_pos_out |=>
    rx_tvalid_out) else $error("frame last without data");
  mf_begin_a: assert property ((multiframe_begin_byte_pos_out &
    ~frame_begin_byte_pos_out) == 4'h0) else $error("mf begin alone");
  mf_last_a: assert property ((multiframe_last_byte_pos_out &
    ~frame_last_byte_pos_out) == 4'h0) else $error("mf last alone");
  bresp_okay_a: assert property (s_axi_bvalid_out |->
    s_axi_bresp_out == rfb_pkg::RESP_OKAY) else $error("bad bresp");
  rresp_okay_a: assert property (s_axi_rvalid_out |->
    s_axi_rresp_out == rfb_pkg::RESP_OKAY) else $error("bad rresp");
endmodule

bind rfb_top rfb_props #(.LANES(LANES)) u_props (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
  .lane_data_in(lane_data_in), .lane_byte_err_in(lane_byte_err_in),
  .lane_valid_in(lane_valid_in), .comma_aligned_in(comma_aligned_in),
  .rx_tdata_out(rx_tdata_out), .rx_tvalid_out(rx_tvalid_out),
  .frame_begin_byte_pos_out(frame_begin_byte_pos_out),
  .frame_last_byte_pos_out(frame_last_byte_pos_out),
  .multiframe_begin_byte_pos_out(multiframe_begin_byte_pos_out),
  .multiframe_last_byte_pos_out(multiframe_last_byte_pos_out),
  .rx_frame_error_out(rx_frame_error_out), .rx_sync_n_out(rx_sync_n_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out));

// ---- dv/rfb_user_model.sv ----
/*
  Downstream user logic: counts delivered words and patches errored bytes.
  Assumes four lanes and error flags one cycle ahead of their bytes.
*/
`timescale 1ns/100ps
module rfb_user_model (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Delivered stream.
  input wire logic [127:0] tdata_in,
  input wire logic tvalid_in,
  input wire logic [15:0] err_in,
  // Words received so far and errored bytes among them.
  output int word_cnt_out,
  output int bad_cnt_out
);
  logic [15:0] err_q;
  logic [127:0] last_q;
  // The port keeps no old frame, so errored bytes keep the last good one.
  always_ff @(posedge clk_in) begin
    err_q <= err_in;
    if (!resetn_in) begin
      word_cnt_out <= 0;
      bad_cnt_out <= 0;
    end else if (tvalid_in) begin
      word_cnt_out <= word_cnt_out + 1;
      bad_cnt_out <= bad_cnt_out + $countones(err_q);
      for (int b = 0; b < 16; b++) begin
        if (!err_q[b]) begin
          last_q[8*b +: 8] <= tdata_in[8*b +: 8];
        end
      end
    end
  end
endmodule

// ---- dv/rfb_tb_top.sv ----
/*
  Self-checking bench for rfb_top: random lane words with corner cases,
  a reference of flags and latencies, and management accesses.
  Assumes four lanes and the management port on the core clock.
*/
`timescale 1ns/100ps
module rfb_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic lv = 1'b0, cm = 1'b0, tv, sn, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic awr, wr, arr, bv, rv, s_m, v1, e_tv;
  logic [127:0] ld = '0, td, d1, e_td;
  logic [15:0] le = '0, fe, e_err;
  logic [3:0] fb, fl, mb, ml, e_fb, e_fl, e_mb, e_ml;
  logic [11:0] aa = '0;
  logic [31:0] wd = '0, rd;
  logic [1:0] br, rr;
  logic sr = 1'b0, sc1 = 1'b0;
  logic [2:0] sp = '0;
  int errors = 0, n_tests = 0, cyc = 0, f_cfg = 8, k_cfg = 32;
  int pos, mf, taken = 0, got, nbad = 0, bad;

  // Clock at 40 MHz.
  always #12.5 clk = ~clk;

  rfb_top #(.LANES(4)) u_dut (.ref_clk_in(clk), .resetn_in(rstn),
    .lane_data_in(ld), .lane_byte_err_in(le), .lane_valid_in(lv),
    .comma_aligned_in(cm), .sysref_in(sr), .rx_tdata_out(td),
    .rx_tvalid_out(tv), .frame_begin_byte_pos_out(fb),
    .frame_last_byte_pos_out(fl), .multiframe_begin_byte_pos_out(mb),
    .multiframe_last_byte_pos_out(ml), .rx_frame_error_out(fe),
    .rx_sync_n_out(sn), .s_axi_aresetn_in(rstn), .s_axi_awaddr_in(aa),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1),
    .s_axi_araddr_in(aa), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(1'b1));

  rfb_user_model u_user (.clk_in(clk), .resetn_in(rstn), .tdata_in(td),
    .tvalid_in(tv), .err_in(fe), .word_cnt_out(got), .bad_cnt_out(bad));

  // Byte b is marked when its place in the period equals the offset.
  function automatic logic [3:0] marks(int p, int m, int off);
    logic [3:0] r;
    for (int b = 0; b < 4; b++) r[b] = ((p + b) % m) == off;
    return r;
  endfunction

  // Reference: flags one cycle after a word is taken, data two.
  always @(posedge clk) begin
    mf = f_cfg * k_cfg;
    if (!rstn) begin
      {s_m, v1, e_tv, e_err, e_fb, e_fl, e_mb, e_ml} = '0;
      pos = 0;
      sp = 3'h0;
    end else begin
      e_tv = v1;
      e_td = d1;
      v1 = lv && s_m;
      d1 = ld;
      e_err = lv ? le : 16'h0;
      e_fb = v1 ? marks(pos, f_cfg, 0) : 4'h0;
      e_fl = v1 ? marks(pos, f_cfg, f_cfg - 1) : 4'h0;
      e_mb = v1 ? marks(pos, mf, 0) : 4'h0;
      e_ml = v1 ? marks(pos, mf, mf - 1) : 4'h0;
      pos = !s_m ? 0 : v1 ? (pos + 4) % mf : pos;
      if (sc1 && sp[1] && !sp[2]) pos = 0;
      sp = {sp[1:0], sr};
      taken += v1;
      nbad += v1 ? $countones(le) : 0;
      s_m = cm;
    end
  end

  task automatic chk_s(input string nm, input logic [3:0] e,
                       input logic [3:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_w(input string nm, input logic [127:0] e,
                       input logic [127:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Outputs are settled by the falling edge.
  always @(negedge clk) begin
    if (rstn) begin
      chk_s("sync", {3'h0, s_m}, {3'h0, sn});
      chk_s("tvalid", {3'h0, e_tv}, {3'h0, tv});
      chk_s("fbegin", e_fb, fb);
      chk_s("flast", e_fl, fl);
      chk_s("mbegin", e_mb, mb);
      chk_s("mlast", e_ml, ml);
      chk_w("err", {112'h0, e_err}, {112'h0, fe});
      if (e_tv) chk_w("data", e_td, td);
    end
  end

  // Write: hold address and data until the edge that sees both readies.
  task automatic mwr(input logic [11:0] a, input logic [31:0] d);
    aa = a;
    wd = d;
    awv = 1'b1;
    wv = 1'b1;
    @(negedge clk);
    while (!(awr && wr)) @(negedge clk);
    @(posedge clk);
    #1;
    awv = 1'b0;
    wv = 1'b0;
    @(negedge clk);
    while (!bv) @(negedge clk);
    chk_s("bresp", 4'h0, {2'h0, br});
    @(posedge clk);
    #1;
  endtask

  task automatic mrd(input logic [11:0] a, input logic [31:0] e);
    aa = a;
    arv = 1'b1;
    @(negedge clk);
    while (!arr) @(negedge clk);
    @(posedge clk);
    #1;
    arv = 1'b0;
    @(negedge clk);
    while (!rv) @(negedge clk);
    chk_s("rresp", 4'h0, {2'h0, rr});
    chk_w("rdata", {96'h0, e}, {96'h0, rd});
    @(posedge clk);
    #1;
  endtask

  // Random words; comma alignment drops for three cycles at drop.
  task automatic run(input string nm, input int n, input bit dense,
                     input int drop);
    for (int i = 0; i < n; i++) begin
      lv = dense ? 1'b1 : ($urandom % 4) != 0;
      ld = {$urandom, $urandom, $urandom, $urandom};
      le = ($urandom % 8) == 0 ? 16'($urandom) : 16'h0;
      cm = !(i >= drop && i < drop + 3);
      sr = ($urandom % 32) == 0;
      @(posedge clk);
      #1;
    end
    lv = 1'b0;
    sr = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk_w("words", 128'(taken), 128'(got));
    chk_w("bad bytes", 128'(nbad), 128'(bad));
    $display("test %s done, errors %0d", nm, errors);
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog well above the roughly 720 cycles the tests need.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    void'($urandom(22621));
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    mrd(12'h000, {15'h0, rfb_pkg::SC1_RST, rfb_pkg::FRAMES_RST,
        rfb_pkg::OCTETS_RST});
    mrd(12'h004, 32'h0);
    mwr(12'h100, 32'hFFFFFFFF);
    mrd(12'h100, 32'h0);
    run("default_framing", 300, 1'b0, 1000);
    run("back_to_back_abort", 80, 1'b1, 40);
    mrd(12'h004, 32'h1);
    cm = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    mwr(12'h000, 32'h00010307);
    f_cfg = 7;
    k_cfg = 3;
    sc1 = 1'b1;
    mrd(12'h000, 32'h00010307);
    run("odd_frame_sysref", 300, 1'b0, 1000);
    final_report();
  end
endmodule
